// [hw/light_proximity_i2c_command.sv]
`timescale 1ns/1ps

// Operation
// - Twelve 8-bit registers, all reachable over bus.
// - Same logic serves standard, fast, high speed.
// - Answer only target address 13h.
// - Register addresses 80h to 8Bh map indices.
// - Command register holds starts and ready flags.
// - Lock bit always reads one.
// - Light ready sets when result stored.
// - Reading register 5 or 6 clears light ready.
// - Light start bit runs one light measurement.
// - Averaging runs series, stores averaged value.
// - Nearness start bit runs one nearness measurement.
// - Both start bits together measure simultaneously.
// - Averaged conversions number two to the field.
module light_proximity_i2c_command
	import light_prox_pkg::*;
#(
	parameter logic [7:0] PRODUCT_ID = 8'h5a, // Arbitrary value.
	parameter logic [1:0] FUSE_ID = 2'h1 // Arbitrary value.
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic light_sample_valid,
	input wire logic [SAMPLE_W-1:0] light_sample_data,
	output logic light_sample_req,
	input wire logic prox_sample_valid,
	input wire logic [SAMPLE_W-1:0] prox_sample_data,
	output logic prox_sample_req,
	output logic [LED_W-1:0] led_current,
	output logic light_cont_mode,
	output logic light_offset_comp
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	target_state_type cur; // Registered state.
	target_state_type next_cur; // Next state.
	logic scl_rise; // Clock line went high.
	logic scl_fall; // Clock line went low.
	logic start_det; // Start condition seen.
	logic stop_det; // Stop condition seen.
	logic [7:0] rd_byte; // Register at the pointer.
	logic load_rd; // Load rd_byte for sending.
	logic light_go; // One-cycle light start.
	logic prox_go; // One-cycle nearness start.
	logic light_busy; // Light measurement running.
	logic prox_busy; // Nearness measurement running.
	logic light_done; // Light result just stored.
	logic prox_done; // Nearness result just stored.
	logic [SAMPLE_W-1:0] light_res; // Light result.
	logic [SAMPLE_W-1:0] prox_res; // Nearness result.
	logic ptr_ok; // Pointer lies inside the map.

	// ----------------------------------------------------------------
	// Line events
	// ----------------------------------------------------------------

	// Events use the second and third sync stages only. The same edge
	// logic serves every bus speed with no setting to change.
	assign scl_rise = cur.scl_s2 && !cur.scl_s3;
	assign scl_fall = !cur.scl_s2 && cur.scl_s3;
	assign start_det = cur.scl_s2 && cur.scl_s3 && !cur.sda_s2 && cur.sda_s3;
	assign stop_det = cur.scl_s2 && cur.scl_s3 && cur.sda_s2 && !cur.sda_s3;
	assign ptr_ok = (cur.ptr < REG_COUNT);

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------

	// Selects the byte at the pointer; outside the map it reads zero.
	always_comb begin
		rd_byte = 8'h00;
		case (cur.ptr)
			IDX_CMD: begin
				rd_byte[CMD_LOCK] = 1'b1;
				rd_byte[CMD_LRDY] = cur.light_rdy;
				rd_byte[CMD_PRDY] = cur.prox_rdy;
				rd_byte[CMD_LGO] = light_busy;
				rd_byte[CMD_PGO] = prox_busy;
			end
			IDX_ID: begin
				rd_byte = PRODUCT_ID;
			end
			IDX_LED: begin
				rd_byte = {FUSE_ID, cur.led};
			end
			IDX_AMB: begin
				rd_byte[AMB_CONT] = cur.cont_mode;
				rd_byte[AMB_OFFS] = cur.offs_comp;
				rd_byte[AVG_W-1:0] = cur.avg;
			end
			IDX_LRES_HI: begin
				rd_byte = light_res[15:8];
			end
			IDX_LRES_LO: begin
				rd_byte = light_res[7:0];
			end
			IDX_PRES_HI: begin
				rd_byte = prox_res[15:8];
			end
			IDX_PRES_LO: begin
				rd_byte = prox_res[7:0];
			end
			4'h9, 4'ha, 4'hb: begin
				rd_byte = cur.spare[2'(cur.ptr - IDX_SPARE)];
			end
			default: begin
				rd_byte = 8'h00;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Target state machine
	// ----------------------------------------------------------------

	// Samples on the rising clock edge and changes the data line on
	// the falling edge, as the bus requires.
	always_comb begin
		next_cur = cur;
		next_cur.scl_s1 = scl_in;
		next_cur.scl_s2 = cur.scl_s1;
		next_cur.scl_s3 = cur.scl_s2;
		next_cur.sda_s1 = sda_in;
		next_cur.sda_s2 = cur.sda_s1;
		next_cur.sda_s3 = cur.sda_s2;
		next_cur.sda_out = 1'b0;
		load_rd = 1'b0;
		light_go = 1'b0;
		prox_go = 1'b0;
		if (start_det) begin
			// A start, repeated or not, always restarts the address phase.
			next_cur.st = BUS_ADDR;
			next_cur.cnt = 4'h0;
			next_cur.sda_oe = 1'b0;
		end else if (stop_det) begin
			next_cur.st = BUS_IDLE;
			next_cur.sda_oe = 1'b0;
		end else begin
			case (cur.st)
				BUS_IDLE: begin
					next_cur.sda_oe = 1'b0;
				end
				BUS_ADDR, BUS_WR: begin
					// Shift in one bit per rising clock edge.
					if (scl_rise) begin
						next_cur.shift = {cur.shift[6:0], cur.sda_s2};
						next_cur.cnt = 4'(cur.cnt + 4'h1);
					end
					if (scl_fall && cur.cnt == BYTE_BITS) begin
						if (cur.st == BUS_ADDR) begin
							// Other targets' addresses are left alone.
							if (cur.shift[7:1] == DEV_ADDR) begin
								next_cur.is_read = cur.shift[0];
								next_cur.first_byte = 1'b1;
								next_cur.sda_oe = 1'b1;
								next_cur.st = BUS_ADDR_ACK;
							end else begin
								next_cur.st = BUS_IDLE;
							end
						end else begin
							next_cur.sda_oe = 1'b1;
							next_cur.st = BUS_WR_ACK;
							if (cur.first_byte) begin
								// First data byte selects the register.
								next_cur.first_byte = 1'b0;
								if (cur.shift >= REG_BASE && cur.shift <= REG_LAST) begin
									next_cur.ptr = cur.shift[3:0];
								end else begin
									next_cur.ptr = PTR_NONE;
								end
							end else if (ptr_ok) begin
								next_cur.ptr = 4'(cur.ptr + 4'h1);
								case (cur.ptr)
									IDX_CMD: begin
										// Both bits in one write start both at once.
										light_go = cur.shift[CMD_LGO];
										prox_go = cur.shift[CMD_PGO];
									end
									IDX_LED: begin
										next_cur.led = cur.shift[LED_W-1:0];
									end
									IDX_AMB: begin
										next_cur.cont_mode = cur.shift[AMB_CONT];
										next_cur.offs_comp = cur.shift[AMB_OFFS];
										next_cur.avg = cur.shift[AVG_W-1:0];
									end
									4'h9, 4'ha, 4'hb: begin
										next_cur.spare[2'(cur.ptr - IDX_SPARE)] = cur.shift;
									end
									default: begin
										// Read-only registers ignore writes.
									end
								endcase
							end
						end
					end
				end
				BUS_ADDR_ACK: begin
					// Acknowledge ends on the falling edge.
					if (scl_fall) begin
						next_cur.cnt = 4'h0;
						next_cur.sda_oe = 1'b0;
						if (cur.is_read) begin
							load_rd = 1'b1;
						end else begin
							next_cur.st = BUS_WR;
						end
					end
				end
				BUS_WR_ACK: begin
					if (scl_fall) begin
						next_cur.cnt = 4'h0;
						next_cur.sda_oe = 1'b0;
						next_cur.st = BUS_WR;
					end
				end
				BUS_RD: begin
					// Shift out the next bit, or release for the host's ack.
					if (scl_fall) begin
						if (cur.cnt == BYTE_BITS) begin
							next_cur.sda_oe = 1'b0;
							next_cur.st = BUS_RD_ACK;
						end else begin
							next_cur.sda_oe = !cur.shift[6];
							next_cur.shift = {cur.shift[6:0], 1'b0};
							next_cur.cnt = 4'(cur.cnt + 4'h1);
						end
					end
				end
				BUS_RD_ACK: begin
					// A not-acknowledge ends the read.
					if (scl_rise && cur.sda_s2) begin
						next_cur.st = BUS_IDLE;
					end else if (scl_fall) begin
						load_rd = 1'b1;
					end
				end
				default: begin
					next_cur.st = BUS_IDLE;
					next_cur.sda_oe = 1'b0;
				end
			endcase
		end
		if (load_rd) begin
			// Drive the first bit of the byte and step the pointer.
			next_cur.shift = rd_byte;
			next_cur.sda_oe = !rd_byte[7];
			next_cur.cnt = 4'h1;
			next_cur.st = BUS_RD;
			if (ptr_ok) begin
				next_cur.ptr = 4'(cur.ptr + 4'h1);
			end
		end
		// A result that lands in the cycle of its read still sets the flag.
		next_cur.light_rdy = (cur.light_rdy && !(load_rd &&
			(cur.ptr == IDX_LRES_HI || cur.ptr == IDX_LRES_LO))) || light_done;
		next_cur.prox_rdy = (cur.prox_rdy && !(load_rd &&
			(cur.ptr == IDX_PRES_HI || cur.ptr == IDX_PRES_LO))) || prox_done;
	end

	// State register.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cur <= '0;
			cur.scl_s1 <= 1'b1;
			cur.scl_s2 <= 1'b1;
			cur.scl_s3 <= 1'b1;
			cur.sda_s1 <= 1'b1;
			cur.sda_s2 <= 1'b1;
			cur.sda_s3 <= 1'b1;
			cur.st <= BUS_IDLE;
			cur.ptr <= PTR_NONE;
			cur.led <= RST_LED;
			cur.avg <= RST_AVG;
		end else begin
			cur <= next_cur;
		end
	end

	// ----------------------------------------------------------------
	// Measurement sequencers
	// ----------------------------------------------------------------

	// Light measurement averages 2**avg conversions.
	conv_sequencer light_seq (
		.core_clk(core_clk),
		.rst(rst),
		.start(light_go),
		.avg_log2(cur.avg),
		.sample_valid(light_sample_valid),
		.sample_data(light_sample_data),
		.sample_req(light_sample_req),
		.busy(light_busy),
		.done(light_done),
		.result(light_res)
	);

	// Nearness measurement is one conversion.
	conv_sequencer prox_seq (
		.core_clk(core_clk),
		.rst(rst),
		.start(prox_go),
		.avg_log2(3'h0),
		.sample_valid(prox_sample_valid),
		.sample_data(prox_sample_data),
		.sample_req(prox_sample_req),
		.busy(prox_busy),
		.done(prox_done),
		.result(prox_res)
	);

	assign sda_out = cur.sda_out;
	assign sda_oe = cur.sda_oe;
	assign led_current = cur.led;
	assign light_cont_mode = cur.cont_mode;
	assign light_offset_comp = cur.offs_comp;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	addr_match_a: assert property (@(posedge core_clk) disable iff (rst)
		(cur.st == BUS_ADDR && !start_det && !stop_det && scl_fall &&
		cur.cnt == BYTE_BITS && cur.shift[7:1] == DEV_ADDR)
		|=> cur.st == BUS_ADDR_ACK && sda_oe)
		else $error("own address not acknowledged");

	addr_other_a: assert property (@(posedge core_clk) disable iff (rst)
		(cur.st == BUS_ADDR && !start_det && !stop_det && scl_fall &&
		cur.cnt == BYTE_BITS && cur.shift[7:1] != DEV_ADDR)
		|=> cur.st == BUS_IDLE && !sda_oe)
		else $error("foreign address acknowledged");

	dir_bit_a: assert property (@(posedge core_clk) disable iff (rst)
		(cur.st == BUS_ADDR_ACK && $past(cur.st) == BUS_ADDR)
		|-> cur.is_read == $past(cur.shift[0]))
		else $error("direction bit not taken");

	reg_select_a: assert property (@(posedge core_clk) disable iff (rst)
		(cur.st == BUS_WR && cur.first_byte && scl_fall && !start_det &&
		!stop_det && cur.cnt == BYTE_BITS && cur.shift[7:4] == 4'h8 &&
		cur.shift[3:0] < REG_COUNT) |=> cur.ptr == $past(cur.shift[3:0]))
		else $error("register address not decoded");

	lock_bit_a: assert property (@(posedge core_clk) disable iff (rst)
		(load_rd && cur.ptr == IDX_CMD) |=> cur.shift[CMD_LOCK] && !sda_oe)
		else $error("lock bit read as zero");

	light_flag_a: assert property (@(posedge core_clk) disable iff (rst)
		light_done |=> cur.light_rdy ##1 (cur.light_rdy ||
		$past(load_rd && (cur.ptr == IDX_LRES_HI || cur.ptr == IDX_LRES_LO))))
		else $error("light ready flag wrong");

	prox_clear_a: assert property (@(posedge core_clk) disable iff (rst)
		(load_rd && cur.ptr == IDX_PRES_LO && !prox_done) |=> !cur.prox_rdy)
		else $error("nearness ready not cleared by read");

	both_start_a: assert property (@(posedge core_clk) disable iff (rst)
		(light_go && prox_go && !light_busy && !prox_busy)
		|=> light_busy && prox_busy && light_sample_req && prox_sample_req)
		else $error("joint start did not run both");

endmodule // light_proximity_i2c_command

// [hw/light_prox_pkg.sv]
package light_prox_pkg;

	// ----------------------------------------------------------------
	// Bus addressing
	// ----------------------------------------------------------------
	localparam logic [6:0] DEV_ADDR = 7'h13; // Fixed target address.
	localparam logic [7:0] REG_BASE = 8'h80; // Address of register 0.
	localparam logic [7:0] REG_LAST = 8'h8b; // Address of register 11.
	localparam logic [3:0] REG_COUNT = 4'hc; // Number of registers.
	localparam logic [3:0] PTR_NONE = 4'hf; // Pointer outside the map.
	localparam logic [3:0] BYTE_BITS = 4'h8; // Bits in one byte.

	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam logic [3:0] IDX_CMD = 4'h0; // Measurement command.
	localparam logic [3:0] IDX_ID = 4'h1; // Product identity.
	localparam logic [3:0] IDX_LED = 4'h3; // Emitter current.
	localparam logic [3:0] IDX_AMB = 4'h4; // Light parameters.
	localparam logic [3:0] IDX_LRES_HI = 4'h5; // Light result, high.
	localparam logic [3:0] IDX_LRES_LO = 4'h6; // Light result, low.
	localparam logic [3:0] IDX_PRES_HI = 4'h7; // Nearness result, high.
	localparam logic [3:0] IDX_PRES_LO = 4'h8; // Nearness result, low.
	localparam logic [3:0] IDX_SPARE = 4'h9; // First plain storage byte.

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CMD_LOCK = 7; // Lock flag, reads as one.
	localparam int CMD_LRDY = 6; // Light result ready.
	localparam int CMD_PRDY = 5; // Nearness result ready.
	localparam int CMD_LGO = 4; // Light single shot.
	localparam int CMD_PGO = 3; // Nearness single shot.
	localparam int AMB_CONT = 7; // Continuous conversion mode.
	localparam int AMB_OFFS = 3; // Automatic offset compensation.

	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int LED_W = 6; // Writable emitter current bits.
	localparam int AVG_W = 3; // Averaging exponent width.
	localparam int SAMPLE_W = 16; // One conversion result.
	localparam int ACC_W = 23; // Sum of up to 128 samples.
	localparam int CNT_W = 8; // Sample counter width.
	localparam logic [LED_W-1:0] RST_LED = 6'h02; // 20 mA.
	localparam logic [AVG_W-1:0] RST_AVG = 3'h5; // 32 conversions.

	// ----------------------------------------------------------------
	// State types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_WR, BUS_WR_ACK,
		BUS_RD, BUS_RD_ACK
	} bus_state_type;

	typedef enum logic [1:0] {CONV_IDLE, CONV_RUN, CONV_DONE} conv_state_type;

	// Target interface and register state.
	typedef struct packed {
		logic scl_s1;
		logic scl_s2;
		logic scl_s3;
		logic sda_s1;
		logic sda_s2;
		logic sda_s3;
		bus_state_type st;
		logic [3:0] cnt;
		logic [7:0] shift;
		logic is_read;
		logic first_byte;
		logic [3:0] ptr;
		logic sda_out;
		logic sda_oe;
		logic light_rdy;
		logic prox_rdy;
		logic [LED_W-1:0] led;
		logic cont_mode;
		logic offs_comp;
		logic [AVG_W-1:0] avg;
		logic [2:0][7:0] spare;
	} target_state_type;

	// Conversion sequencer state.
	typedef struct packed {
		conv_state_type st;
		logic req;
		logic done;
		logic [CNT_W-1:0] cnt;
		logic [ACC_W-1:0] acc;
		logic [SAMPLE_W-1:0] result;
	} conv_reg_type;

endpackage

// [hw/conv_sequencer.sv]
`timescale 1ns/1ps

// Runs one on-demand measurement of 2**avg_log2 conversions and keeps
// the average of them.
module conv_sequencer
	import light_prox_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [AVG_W-1:0] avg_log2,
	input wire logic sample_valid,
	input wire logic [SAMPLE_W-1:0] sample_data,
	output logic sample_req,
	output logic busy,
	output logic done,
	output logic [SAMPLE_W-1:0] result
);

	conv_reg_type cur; // Registered state.
	conv_reg_type next_cur; // Next state.
	logic [CNT_W-1:0] total; // Conversions in this measurement.
	logic [ACC_W-1:0] sum; // Accumulator with the new sample.

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------

	// The exponent is read live; software must not change it mid-run.
	always_comb begin
		total = CNT_W'(8'h01 << avg_log2);
		sum = cur.acc + {{(ACC_W-SAMPLE_W){1'b0}}, sample_data};
		next_cur = cur;
		next_cur.done = 1'b0;
		case (cur.st)
			CONV_IDLE: begin
				// A start while running is ignored.
				if (start) begin
					next_cur.st = CONV_RUN;
					next_cur.req = 1'b1;
					next_cur.cnt = '0;
					next_cur.acc = '0;
				end
			end
			CONV_RUN: begin
				// Each accepted sample is summed into the accumulator.
				if (sample_valid) begin
					next_cur.acc = sum;
					next_cur.cnt = CNT_W'(cur.cnt + 8'h01);
					if (CNT_W'(cur.cnt + 8'h01) == total) begin
						next_cur.req = 1'b0;
						next_cur.result = SAMPLE_W'(sum >> avg_log2);
						next_cur.st = CONV_DONE;
					end
				end
			end
			CONV_DONE: begin
				// One cycle of done once the result stands.
				next_cur.done = 1'b1;
				next_cur.st = CONV_IDLE;
			end
			default: begin
				next_cur.st = CONV_IDLE;
			end
		endcase
	end

	// State register.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign sample_req = cur.req;
	assign busy = (cur.st != CONV_IDLE);
	assign done = cur.done;
	assign result = cur.result;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	conv_start_a: assert property (@(posedge core_clk) disable iff (rst)
		(cur.st == CONV_IDLE && start) |=> busy && sample_req)
		else $error("start did not begin a conversion");

	avg_count_a: assert property (@(posedge core_clk) disable iff (rst)
		(cur.st == CONV_RUN && sample_valid && CNT_W'(cur.cnt + 8'h01) == total)
		|=> !sample_req ##1 done)
		else $error("averaging did not end after the set count");

endmodule // conv_sequencer

// [testbench/i2c_host_model.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------
// Bus host model
// ------------------------------------------------------------
// Drives the clock and pulls data low, one third of a bit every Q
// cycles, so the clock stays low well over five core cycles.
module i2c_host_model
(
	input wire logic core_clk,
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	localparam int Q = 8; // Core cycles per third of a bit.

	// The bus idles released, with the clock high.
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// Waits n rising edges of the core clock.
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// Start or repeated start: data falls while the clock is high.
	task automatic start();
		sda_low <= 1'b0;
		tick(Q);
		scl <= 1'b1;
		tick(Q);
		sda_low <= 1'b1;
		tick(Q);
		scl <= 1'b0;
		tick(Q);
	endtask

	// Stop: data rises while the clock is high.
	task automatic stop();
		sda_low <= 1'b1;
		tick(Q);
		scl <= 1'b1;
		tick(Q);
		sda_low <= 1'b0;
		tick(Q);
	endtask

	// One bit: data set while low, sampled at the end of the high.
	task automatic bit_cycle(input logic b, output logic got);
		sda_low <= ~b;
		tick(Q);
		scl <= 1'b1;
		tick(Q);
		got = sda;
		scl <= 1'b0;
		tick(Q);
	endtask

	// Sends a byte most significant bit first and returns the ack.
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--) bit_cycle(b[i], g);
		bit_cycle(1'b1, g);
		ack = ~g;
	endtask

	// Receives a byte; the last one is answered with a no-ack.
	task automatic recv_byte(input logic last, output logic [7:0] b);
		logic g;
		for (int i = 7; i >= 0; i--) bit_cycle(1'b1, b[i]);
		bit_cycle(last, g);
	endtask
endmodule // i2c_host_model

// [testbench/light_proximity_i2c_command_bench.sv]
`timescale 1ns/1ps

`define CHECK(what, exp, got) begin checks++; if ((got) !== (exp)) begin \
	failures++; $display("[ERR] %s expected %h seen %h", what, exp, got); \
	end end

module light_proximity_i2c_command_bench import light_prox_pkg::*;;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam logic [1:0] FUSE = 2'h2; // Arbitrary value.
	logic core_clk, rst, scl_in, host_low, sda_out, sda_oe;
	logic light_sample_valid, light_sample_req;
	logic prox_sample_valid, prox_sample_req;
	logic [SAMPLE_W-1:0] light_sample_data, prox_sample_data;
	logic [LED_W-1:0] led_current;
	logic light_cont_mode, light_offset_comp, both_seen;
	logic [15:0] lval, pval, lres, pres, lv; // Sample source, results.
	logic [ACC_W-1:0] sum;
	logic [7:0] rbuf [0:3]; // Bytes of the last read.
	int failures = 0;
	int checks = 0;
	logic [2:0] avg_t [5] = '{3'h2, 3'h0, 3'h3, 3'h7, 3'h0};
	logic [7:0] cmd_t [5] = '{8'h18, 8'h10, 8'h10, 8'h10, 8'h08};
	// Open-drain data wire with a pull-up.
	wire logic sda_line = (sda_oe ? sda_out : 1'b1) & ~host_low;

	light_proximity_i2c_command #(.PRODUCT_ID(8'h3c), .FUSE_ID(FUSE)) i_dut (
		.core_clk(core_clk), .rst(rst), .scl_in(scl_in),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
		.light_sample_valid(light_sample_valid),
		.light_sample_data(light_sample_data),
		.light_sample_req(light_sample_req),
		.prox_sample_valid(prox_sample_valid),
		.prox_sample_data(prox_sample_data),
		.prox_sample_req(prox_sample_req), .led_current(led_current),
		.light_cont_mode(light_cont_mode),
		.light_offset_comp(light_offset_comp));

	i2c_host_model i_host (.core_clk(core_clk), .scl(scl_in),
		.sda_low(host_low), .sda(sda_line));

	// ------------------------------------------------------------
	// Front end and clock
	// ------------------------------------------------------------
	// Samples come every other cycle with a rising value, so a
	// wrong sample count shows in the average.
	always @(posedge core_clk) begin
		light_sample_valid <= light_sample_req & ~light_sample_valid;
		prox_sample_valid <= prox_sample_req & ~prox_sample_valid;
		if (light_sample_req & ~light_sample_valid) begin
			light_sample_data <= lval;
			lval <= lval + 16'h0100;
		end
		if (prox_sample_req & ~prox_sample_valid) begin
			prox_sample_data <= pval;
			pval <= pval + 16'h0011;
		end
		if (light_sample_req & prox_sample_req) both_seen <= 1'b1;
	end

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// ------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------
	// Sends one byte and compares the answer with the expected ack.
	task automatic send_chk(input logic [7:0] b, input logic exp_ack);
		logic a;
		i_host.send_byte(b, a);
		`CHECK("ack", exp_ack, a)
	endtask

	// Writes one register.
	task automatic wr(input logic [7:0] r, input logic [7:0] d);
		i_host.start();
		send_chk({DEV_ADDR, 1'b0}, 1'b1);
		send_chk(r, 1'b1);
		send_chk(d, 1'b1);
		i_host.stop();
	endtask

	// Reads n bytes from register r on into rbuf.
	task automatic rd(input logic [7:0] r, input int n);
		i_host.start();
		send_chk({DEV_ADDR, 1'b0}, 1'b1);
		send_chk(r, 1'b1);
		i_host.start();
		send_chk({DEV_ADDR, 1'b1}, 1'b1);
		for (int i = 0; i < n; i++) i_host.recv_byte(i == n - 1, rbuf[i]);
		i_host.stop();
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic close_out();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	// Watchdog: a hang counts as a mismatch. The tests need about
	// 43,000 cycles, so this limit leaves ample room.
	initial begin
		repeat (80000) @(posedge core_clk);
		failures++;
		close_out();
	end

	initial begin
		rst = 1'b1;
		light_sample_valid = 1'b0;
		prox_sample_valid = 1'b0;
		light_sample_data = 16'h0000;
		prox_sample_data = 16'h0000;
		lval = 16'h1000;
		pval = 16'h2345;
		both_seen = 1'b0;
		lres = 16'h0000;
		pres = 16'h0000;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		repeat (5) @(posedge core_clk);
		`CHECK("led reset", RST_LED, led_current)
		rd(8'h80, 1);
		`CHECK("cmd reset", 8'h80, rbuf[0])
		wr(8'h83, 8'h14);
		`CHECK("led", 6'h14, led_current)
		rd(8'h83, 1);
		`CHECK("reg3", {FUSE, 6'h14}, rbuf[0])
		wr(8'h8b, 8'ha5);
		rd(8'h8b, 1);
		`CHECK("reg11", 8'ha5, rbuf[0])
		wr(8'h8c, 8'h55);
		rd(8'h8c, 1);
		`CHECK("unmapped", 8'h00, rbuf[0])
		// A foreign address is left unanswered.
		i_host.start();
		send_chk({7'h14, 1'b0}, 1'b0);
		i_host.stop();
		// Each entry sets the averaging and starts measurements.
		for (int i = 0; i < 5; i++) begin
			wr(8'h84, {5'h11, avg_t[i]});
			`CHECK("cont", 1'b1, light_cont_mode)
			`CHECK("offs", 1'b1, light_offset_comp)
			lv = lval;
			sum = '0;
			for (int k = 0; k < (1 << avg_t[i]); k++) begin
				sum = sum + ACC_W'(lv);
				lv = lv + 16'h0100;
			end
			if (cmd_t[i][4]) lres = 16'(sum >> avg_t[i]);
			if (cmd_t[i][3]) pres = pval;
			both_seen <= 1'b0;
			wr(8'h80, cmd_t[i]);
			for (int k = 0; k < 3000; k++) begin
				if (!(light_sample_req | prox_sample_req)) break;
				@(posedge core_clk);
			end
			// A measurement still running here means the wait ran out.
			`CHECK("meas end", 1'b0, light_sample_req | prox_sample_req)
			repeat (4) @(posedge core_clk);
			rd(8'h80, 1);
			`CHECK("ready", {1'b1, cmd_t[i][4:3], 5'h0}, rbuf[0])
			`CHECK("both", cmd_t[i] == 8'h18, both_seen)
			rd(8'h86, 1);
			`CHECK("light lo", lres[7:0], rbuf[0])
			rd(8'h80, 1);
			`CHECK("light clr", {2'b10, cmd_t[i][3], 5'h0}, rbuf[0])
			rd(8'h87, 2);
			`CHECK("prox hi", pres[15:8], rbuf[0])
			`CHECK("prox lo", pres[7:0], rbuf[1])
			rd(8'h80, 1);
			`CHECK("prox clr", 8'h80, rbuf[0])
			rd(8'h85, 1);
			`CHECK("light hi", lres[15:8], rbuf[0])
		end
		close_out();
	end
endmodule // light_proximity_i2c_command_bench
